// [cal_pkg.sv]
// shared constants, types and helpers for the core calibration link
package cal_pkg;
   // converter geometry
   localparam int NUM_CORES = 5;
   localparam int CORE_W = 3;
   localparam int SAMPLE_W = 14;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_W = SAMPLE_W + 1;

   // timing: 27 ms rotation interval at a 40 MHz clock
   localparam int CLK_HZ = 40_000_000;
   localparam int SWAP_TIME_MS = 27;
   localparam int SWAP_CYCLES_DEF = SWAP_TIME_MS * (CLK_HZ / 1000);
   localparam int BRINGUP_CYCLES_DEF = 256;
   localparam int FG_CYCLES_DEF = 64;
   localparam int BG_CAL_CYCLES_DEF = 1024;
   localparam int TRIG_PULSE_CYCLES = 4;
   localparam int ERR_THRESH_DEF = 16;

   // device register indices on the parallel register write port
   localparam logic [2:0] DEV_REG_CTRL = 3'h0;
   localparam logic [2:0] DEV_REG_CMD = 3'h1;
   localparam int CTRL_BG_EN = 0;
   localparam int CTRL_LP = 1;
   localparam int CTRL_FRZ_EN = 2;
   localparam int CMD_BRINGUP = 0;
   localparam int CMD_FG = 1;

   // device status bits
   localparam int ST_INIT_DONE = 0;
   localparam int ST_BUSY = 1;
   localparam int ST_BG_ACTIVE = 2;
   localparam int ST_SPARE_PWR = 3;
   localparam int ST_SPARE_CAL = 4;
   localparam int ST_SPARE_LSB = 5;

   // host registers on the AHB-Lite bus (byte offsets)
   localparam logic [7:0] H_CTRL = 8'h00;
   localparam logic [7:0] H_CMD = 8'h04;
   localparam logic [7:0] H_PINS = 8'h08;
   localparam logic [7:0] H_STATUS = 8'h0C;
   localparam logic [7:0] H_DATA = 8'h10;
   localparam int HC_AUTO = 3;
   localparam int HCMD_PIN_FG = 2;
   localparam int HTRANS_ACTIVE_BIT = 1;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_BRINGUP = 4'h2,
      ST_RUN = 4'h4,
      ST_FG = 4'h8
   } dev_state_t;

   // next spare index in the rotation
   function automatic logic [CORE_W-1:0] next_core(input logic [CORE_W-1:0] c);
      next_core = (c == CORE_W'(NUM_CORES - 1)) ? '0 : CORE_W'(c + 1'b1);
   endfunction

   // mask of in-service cores: all but the spare
   function automatic logic [NUM_CORES-1:0] core_mask(input logic [CORE_W-1:0] s);
      core_mask = ~(NUM_CORES'(1) << s);
   endfunction
endpackage

// [cal_link_if.sv]
// link between converter core sequencer and downstream processor
`timescale 1ns/1ps
interface cal_link_if;
   logic reg_wr;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata;
   logic [7:0] status;
   logic cal_trig;
   logic freeze;
   logic smp_valid;
   logic smp_ready;
   logic [cal_pkg::SAMPLE_W-1:0] smp_data;
   logic smp_drop;
   logic smp_cal;

   modport dev (
      input reg_wr, reg_addr, reg_wdata, cal_trig, freeze, smp_ready,
      output status, smp_valid, smp_data, smp_drop, smp_cal
   );
   modport host (
      output reg_wr, reg_addr, reg_wdata, cal_trig, freeze, smp_ready,
      input status, smp_valid, smp_data, smp_drop, smp_cal
   );
endinterface

// [cal_device.sv]
// converter core calibration sequencer and sample source
//
// Implementation choices: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
module cal_device #(
   parameter int SWAP_CYCLES = cal_pkg::SWAP_CYCLES_DEF,
   parameter int BRINGUP_CYCLES = cal_pkg::BRINGUP_CYCLES_DEF,
   parameter int FG_CYCLES = cal_pkg::FG_CYCLES_DEF,
   parameter int BG_CAL_CYCLES = cal_pkg::BG_CAL_CYCLES_DEF
) (
   input wire logic CLK,
   input wire logic RST,
   cal_link_if.dev LINK,
   output logic [cal_pkg::NUM_CORES-1:0] CORE_ACTIVE,
   output logic SPARE_PWR,
   output logic CAL_BUSY
);
   import cal_pkg::*;

   dev_state_t state_r;
   logic [31:0] cnt_r;
   logic [31:0] intv_r;
   logic [31:0] spare_cnt_r;
   logic [CORE_W-1:0] spare_r;
   logic spare_cal_r;
   logic init_done_r;
   logic bg_en_r, lp_r, frz_en_r;
   logic trig_s1, trig_s2, trig_s3;
   logic frz_s1, frz_s2;
   logic ctrl_wr, cmd_wr, bringup_go, fg_trig, frozen;
   logic bringup_end, fg_end, swap_now, spare_pwr_nxt;
   logic valid_r, drop_r, cal_flag_r, swap_pend_r;
   logic [SAMPLE_W-1:0] smp_cnt_r, data_r, next_val;
   logic [7:0] status_r;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers; the second stage feeds logic, the third trigger stage only the edge detect
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         trig_s1 <= 1'b0;
         trig_s2 <= 1'b0;
         trig_s3 <= 1'b0;
         frz_s1 <= 1'b0;
         frz_s2 <= 1'b0;
      end else begin
         trig_s1 <= LINK.cal_trig;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         frz_s1 <= LINK.freeze;
         frz_s2 <= frz_s1;
      end
   end

   // register port decode
   assign ctrl_wr = LINK.reg_wr && (LINK.reg_addr == DEV_REG_CTRL);
   assign cmd_wr = LINK.reg_wr && (LINK.reg_addr == DEV_REG_CMD);
   assign bringup_go = cmd_wr && LINK.reg_wdata[CMD_BRINGUP];
   // either a command write or a rising edge on the trigger pin
   assign fg_trig = (cmd_wr && LINK.reg_wdata[CMD_FG]) ||
                    (trig_s2 && !trig_s3);
   assign frozen = frz_en_r && frz_s2;

   // mode configuration; background only ever enabled here
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         bg_en_r <= 1'b0;
         lp_r <= 1'b0;
         frz_en_r <= 1'b0;
      end else if (ctrl_wr) begin
         bg_en_r <= LINK.reg_wdata[CTRL_BG_EN];
         lp_r <= LINK.reg_wdata[CTRL_LP];
         frz_en_r <= LINK.reg_wdata[CTRL_FRZ_EN];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   assign bringup_end = (state_r == ST_BRINGUP) &&
                        (cnt_r == 32'(BRINGUP_CYCLES - 1));
   assign fg_end = (state_r == ST_FG) && (cnt_r == 32'(FG_CYCLES - 1));
   // background swap waits at the end of the interval for a ready spare
   assign swap_now = fg_end ||
      ((state_r == ST_RUN) && bg_en_r && !frozen && spare_cal_r &&
       (intv_r == 32'(SWAP_CYCLES - 1)));

   // main sequencer
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_r <= ST_IDLE;
         cnt_r <= '0;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (bringup_go) begin
                  state_r <= ST_BRINGUP;
                  cnt_r <= '0;
               end
            end
            ST_BRINGUP: begin
               if (bringup_end) begin
                  state_r <= ST_RUN;
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            ST_RUN: begin
               if (bringup_go) begin
                  state_r <= ST_BRINGUP;
                  cnt_r <= '0;
               end else if (fg_trig) begin
                  state_r <= ST_FG;
                  cnt_r <= '0;
               end
            end
            ST_FG: begin
               if (fg_end) begin
                  state_r <= ST_RUN;
               end else begin
                  cnt_r <= cnt_r + 32'h1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // bring-up completion gates the sample stream
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         init_done_r <= 1'b0;
      end else if (bringup_go && (state_r != ST_BRINGUP)) begin
         init_done_r <= 1'b0;
      end else if (bringup_end) begin
         init_done_r <= 1'b1;
      end
   end

   // rotation interval; held, not cleared, while frozen
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         intv_r <= '0;
      end else if (swap_now || !bg_en_r || !init_done_r) begin
         intv_r <= '0;
      end else if ((state_r == ST_RUN) && !frozen &&
                   (intv_r < 32'(SWAP_CYCLES - 1))) begin
         intv_r <= intv_r + 32'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // spare power: always on in plain background mode; low power mode only
   // wakes it for the last stretch before the swap, which saves average
   // power at the price of a supply step at each wake
   always_comb begin
      spare_pwr_nxt = (state_r == ST_BRINGUP) || (state_r == ST_FG);
      if ((state_r == ST_RUN) && bg_en_r && !frozen) begin
         if (!lp_r) begin
            spare_pwr_nxt = 1'b1;
         end else if (intv_r >= 32'(SWAP_CYCLES - BG_CAL_CYCLES)) begin
            spare_pwr_nxt = 1'b1;
         end
      end
   end

   // spare core tracking and its calibration progress
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         spare_r <= '0;
         spare_cal_r <= 1'b0;
         spare_cnt_r <= '0;
      end else if (bringup_end) begin
         spare_cal_r <= 1'b1;
         spare_cnt_r <= '0;
      end else if (swap_now) begin
         spare_r <= next_core(spare_r);
         spare_cal_r <= 1'b0;
         spare_cnt_r <= '0;
      end else if (spare_pwr_nxt && !spare_cal_r) begin
         if (spare_cnt_r == 32'(BG_CAL_CYCLES - 1)) begin
            spare_cal_r <= 1'b1;
         end else begin
            spare_cnt_r <= spare_cnt_r + 32'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // a swap loses the sample slot in flight: the next one skips a count
   assign next_val = swap_pend_r ? SAMPLE_W'(smp_cnt_r + 1'b1) : smp_cnt_r;

   // sample source; stalls under back-pressure from the receiver
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         valid_r <= 1'b0;
         data_r <= '0;
         drop_r <= 1'b0;
         cal_flag_r <= 1'b0;
         smp_cnt_r <= '0;
      end else if (!valid_r || LINK.smp_ready) begin
         valid_r <= init_done_r;
         if (init_done_r) begin
            // foreground output is scrambled, flagged for the receiver
            data_r <= (state_r == ST_FG) ? ~next_val : next_val;
            cal_flag_r <= (state_r == ST_FG);
            drop_r <= swap_pend_r;
            smp_cnt_r <= SAMPLE_W'(next_val + 1'b1);
         end
      end
   end

   // swap seen but not yet reflected in the stream; set beats clear
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         swap_pend_r <= 1'b0;
      end else if (swap_now) begin
         swap_pend_r <= 1'b1;
      end else if ((!valid_r || LINK.smp_ready) && init_done_r) begin
         swap_pend_r <= 1'b0;
      end
   end

   // registered status and user outputs
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         status_r <= '0;
         CORE_ACTIVE <= '0;
         SPARE_PWR <= 1'b0;
         CAL_BUSY <= 1'b0;
      end else begin
         status_r[ST_INIT_DONE] <= init_done_r;
         status_r[ST_BUSY] <= (state_r == ST_BRINGUP) || (state_r == ST_FG);
         status_r[ST_BG_ACTIVE] <= bg_en_r && !frozen;
         status_r[ST_SPARE_PWR] <= spare_pwr_nxt;
         status_r[ST_SPARE_CAL] <= spare_cal_r;
         status_r[7:ST_SPARE_LSB] <= spare_r;
         CORE_ACTIVE <= core_mask(spare_r);
         SPARE_PWR <= spare_pwr_nxt;
         CAL_BUSY <= (state_r == ST_BRINGUP) || (state_r == ST_FG);
      end
   end

   assign LINK.status = status_r;
   assign LINK.smp_valid = valid_r;
   assign LINK.smp_data = data_r;
   assign LINK.smp_drop = drop_r;
   assign LINK.smp_cal = cal_flag_r;
endmodule

// [cal_host.sv]
// downstream processor end: sample FIFO, quality monitor, AHB-Lite slave
`timescale 1ns/1ps
module cal_fifo #(
   parameter int W = cal_pkg::FIFO_W,
   parameter int D = cal_pkg::FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   output logic [$clog2(D+1)-1:0] count
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW-1:0] wp_r, rp_r;
   logic [$clog2(D+1)-1:0] cnt_r;
   logic push, pop;

   assign in_ready = (cnt_r != ($clog2(D+1))'(D));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem[rp_r];
   assign count = cnt_r;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage has no reset; only pointers need a defined start
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_r] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= (wp_r == AW'(D - 1)) ? '0 : AW'(wp_r + 1'b1);
         end
         if (pop) begin
            rp_r <= (rp_r == AW'(D - 1)) ? '0 : AW'(rp_r + 1'b1);
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

////////////////////////////////////////////////////////////////////////////
module cal_host #(
   parameter int ERR_THRESH = cal_pkg::ERR_THRESH_DEF
) (
   input wire logic CLK,
   input wire logic RST,
   cal_link_if.host LINK,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP
);
   import cal_pkg::*;

   logic wr_pend_r;
   logic [7:0] addr_r;
   logic [3:0] ctrl_r;
   logic freeze_r;
   logic [7:0] err_r;
   logic [SAMPLE_W-1:0] exp_r;
   logic [2:0] trig_cnt_r;
   logic trig_r;
   logic regwr_r;
   logic [2:0] regaddr_r;
   logic [7:0] regdata_r;
   logic addr_ok, rd_pop, bus_dev_wr, auto_fire, take, smp_bad;
   logic f_valid;
   logic [FIFO_W-1:0] f_data;
   logic [$clog2(FIFO_DEPTH+1)-1:0] f_cnt;
   logic [31:0] rd_val;

   // received samples are buffered; a full FIFO stalls the source
   cal_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .rst(RST),
      .in_valid(LINK.smp_valid),
      .in_ready(LINK.smp_ready),
      .in_data({LINK.smp_drop, LINK.smp_data}),
      .out_valid(f_valid),
      .out_ready(rd_pop),
      .out_data(f_data),
      .count(f_cnt)
   );

   ////////////////////////////////////////////////////////////////////////
   // AHB address phase; HSIZE ignored, word access only
   assign addr_ok = HSEL && HREADY && HTRANS[HTRANS_ACTIVE_BIT];
   assign rd_pop = addr_ok && !HWRITE && (HADDR[7:0] == H_DATA) && f_valid;

   // read mux, evaluated in the address phase so data is ready at once
   always_comb begin
      case (HADDR[7:0])
         H_CTRL: rd_val = 32'(ctrl_r);
         H_PINS: rd_val = 32'(freeze_r);
         H_STATUS: rd_val = 32'({f_cnt, err_r, LINK.status});
         H_DATA: rd_val = {f_valid, 16'h0000, f_data};
         default: rd_val = 32'h00000000;
      endcase
   end

   // bus slave: zero wait states, always OKAY
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wr_pend_r <= 1'b0;
         addr_r <= '0;
         HRDATA <= '0;
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end else begin
         wr_pend_r <= addr_ok && HWRITE;
         if (addr_ok) begin
            addr_r <= HADDR[7:0];
            if (!HWRITE) begin
               HRDATA <= rd_val;
            end
         end
      end
   end

   // host-side configuration and pin levels
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         ctrl_r <= '0;
         freeze_r <= 1'b0;
      end else if (wr_pend_r) begin
         if (addr_r == H_CTRL) begin
            ctrl_r <= HWDATA[3:0];
         end
         if (addr_r == H_PINS) begin
            freeze_r <= HWDATA[0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // writes that go through to the device register port
   assign bus_dev_wr = wr_pend_r && ((addr_r == H_CTRL) ||
                       ((addr_r == H_CMD) && (|HWDATA[1:0])));
   // automatic request waits for a free port and an idle device
   assign auto_fire = ctrl_r[HC_AUTO] && (err_r >= 8'(ERR_THRESH)) &&
                      !LINK.status[ST_BUSY] && !bus_dev_wr;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         regwr_r <= 1'b0;
         regaddr_r <= '0;
         regdata_r <= '0;
      end else begin
         regwr_r <= bus_dev_wr || auto_fire;
         if (bus_dev_wr && (addr_r == H_CTRL)) begin
            regaddr_r <= DEV_REG_CTRL;
            regdata_r <= 8'(HWDATA[CTRL_FRZ_EN:0]);
         end else if (bus_dev_wr) begin
            regaddr_r <= DEV_REG_CMD;
            regdata_r <= 8'(HWDATA[CMD_FG:0]);
         end else if (auto_fire) begin
            regaddr_r <= DEV_REG_CMD;
            regdata_r <= 8'(1) << CMD_FG;
         end
      end
   end

   // trigger pin pulse, long enough to pass the device synchroniser
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         trig_cnt_r <= '0;
         trig_r <= 1'b0;
      end else begin
         trig_r <= (trig_cnt_r != '0);
         if (wr_pend_r && (addr_r == H_CMD) && HWDATA[HCMD_PIN_FG]) begin
            trig_cnt_r <= 3'(TRIG_PULSE_CYCLES);
         end else if (trig_cnt_r != '0) begin
            trig_cnt_r <= trig_cnt_r - 3'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // quality monitor: samples should count up by one; a flagged swap may
   // skip exactly one, and scrambled calibration output is not judged
   assign take = LINK.smp_valid && LINK.smp_ready;
   assign smp_bad = (LINK.smp_data != exp_r) &&
      !(LINK.smp_drop && (LINK.smp_data == SAMPLE_W'(exp_r + 1'b1)));

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         exp_r <= '0;
         err_r <= '0;
      end else begin
         if (take && !LINK.smp_cal) begin
            exp_r <= SAMPLE_W'(LINK.smp_data + 1'b1);
         end
         if (auto_fire) begin
            err_r <= '0;
         end else if (take && !LINK.smp_cal && smp_bad &&
                      (err_r != 8'hFF)) begin
            err_r <= err_r + 8'h01;
         end
      end
   end

   assign LINK.reg_wr = regwr_r;
   assign LINK.reg_addr = regaddr_r;
   assign LINK.reg_wdata = regdata_r;
   assign LINK.cal_trig = trig_r;
   assign LINK.freeze = freeze_r;
endmodule

// [cal_link_assertions.sv]
// concurrent checks on the converter calibration link
`timescale 1ns/1ps
module cal_link_checker (
   input wire logic CLK,
   input wire logic RST,
   input wire logic reg_wr,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] status,
   input wire logic cal_trig,
   input wire logic freeze,
   input wire logic smp_valid,
   input wire logic smp_ready,
   input wire logic [cal_pkg::SAMPLE_W-1:0] smp_data,
   input wire logic smp_drop,
   input wire logic smp_cal
);
   import cal_pkg::*;
   logic [2:0] ctrl_r;
   logic [2:0] frz_r;
   logic [SAMPLE_W-1:0] prev_r;
   logic have_r;
   wire xfer = smp_valid & smp_ready;
   // foreground samples come inverted; undo that to follow the count
   wire [SAMPLE_W-1:0] raw = smp_cal ? ~smp_data : smp_data;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);

   // shadow of the control field as the device took it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) ctrl_r <= '0;
      else if (reg_wr && reg_addr == DEV_REG_CTRL) ctrl_r <= reg_wdata[2:0];
   end

   // cycles the enabled freeze pin has stood high, saturating
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) frz_r <= '0;
      else if (!(freeze && ctrl_r[CTRL_FRZ_EN])) frz_r <= '0;
      else if (frz_r != 3'h7) frz_r <= frz_r + 3'h1;
   end

   // last sample taken; forgotten while the stream is down for bring-up
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) have_r <= 1'h0;
      else if (xfer) have_r <= 1'h1;
      else if (status[ST_BUSY] && !smp_valid) have_r <= 1'h0;
   end
   always_ff @(posedge CLK) begin
      if (xfer) prev_r <= raw;
   end

   ////////////////////////////////////////////////////////////
   a_valid_after_init: assert property (
      smp_valid |-> status[ST_INIT_DONE]) else $error("sample before init");
   a_stall_holds_data: assert property (
      smp_valid && !smp_ready |=> smp_valid && $stable(smp_data))
      else $error("stalled sample changed");
   a_sample_skip_one: assert property (
      xfer && have_r |-> raw == SAMPLE_W'(prev_r + (smp_drop ? 2 : 1)))
      else $error("sample count broken");
   a_trig_four_cycles: assert property (
      $rose(cal_trig) |-> cal_trig [*4] ##1 !cal_trig)
      else $error("trigger pulse length");
   a_bg_needs_enable: assert property (
      status[ST_BG_ACTIVE] |-> $past(ctrl_r[CTRL_BG_EN]))
      else $error("background without enable");
   a_spare_powered_bg: assert property (
      status[ST_BG_ACTIVE] && $past(status[ST_BG_ACTIVE]) && !ctrl_r[CTRL_LP]
      && !$past(ctrl_r[CTRL_LP]) |-> status[ST_SPARE_PWR])
      else $error("spare unpowered in background");
   a_freeze_stops_bg: assert property (
      frz_r == 3'h7 |-> !status[ST_BG_ACTIVE] && !status[ST_SPARE_PWR])
      else $error("freeze ignored");
   a_freeze_holds_spare: assert property (
      frz_r == 3'h7 |=> $stable(status[ST_SPARE_LSB +: CORE_W]))
      else $error("spare moved while frozen");

   c_drop_seen: cover property (xfer && smp_drop);
   c_stall_seen: cover property (smp_valid && !smp_ready);
   c_freeze_seen: cover property (frz_r == 3'h7);
endmodule

// [interleaved_adc_core_calibration_tb_top.sv]
// testbench: both link ends, bus master and expectation queue
`timescale 1ns/1ps
module interleaved_adc_core_calibration_tb_top;
   import cal_pkg::*;
   localparam int SWAP = 200;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic hsel = 1'h0;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = '0;
   logic hwrite = 1'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [NUM_CORES-1:0] core_act;
   logic spare_pwr;
   logic cal_busy;
   logic [31:0] rdata;
   logic [31:0] seen;
   logic [31:0] exp_q[$];
   string nm_q[$];
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   event got;
   cal_link_if link ();

   // short counts keep the rotation interval simulable
   cal_device #(.SWAP_CYCLES(SWAP), .BRINGUP_CYCLES(8), .FG_CYCLES(8),
      .BG_CAL_CYCLES(16)) cal_device_inst (.CLK(clk), .RST(rst),
      .LINK(link), .CORE_ACTIVE(core_act), .SPARE_PWR(spare_pwr),
      .CAL_BUSY(cal_busy));
   cal_host cal_host_inst (.CLK(clk), .RST(rst), .LINK(link), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
      .HREADYOUT(hreadyout), .HRESP(hresp));
   cal_link_checker cal_link_checker_inst (.CLK(clk), .RST(rst),
      .reg_wr(link.reg_wr), .reg_addr(link.reg_addr),
      .reg_wdata(link.reg_wdata), .status(link.status),
      .cal_trig(link.cal_trig), .freeze(link.freeze),
      .smp_valid(link.smp_valid), .smp_ready(link.smp_ready),
      .smp_data(link.smp_data), .smp_drop(link.smp_drop),
      .smp_cal(link.smp_cal));

   // clock and cycle count
   always #12.5 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] s,
      input logic [31:0] e);
      checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic test_done;
      $display("checks %0d bad %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // single word transfer; no wait count assumed, the watchdog cuts hangs
   task automatic bus(input logic [7:0] a, input logic w,
      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'h1);
      rdata = hrdata;
   endtask

   task automatic rd(input logic [7:0] a, input string nm,
      input logic [31:0] m, input logic [31:0] e);
      nm_q.push_back(nm);
      exp_q.push_back(e & m);
      bus(a, 1'h0, '0);
      seen = rdata & m;
      ->got;
   endtask

   // results are matched against the oldest note when they show up
   always @(got) chk(nm_q.pop_front(), seen, exp_q.pop_front());

   task automatic wait_busy(input logic v);
      int n;
      n = 0;
      while (cal_busy !== v && n < 100) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic wait_idx(input logic [2:0] old);
      int n;
      n = 0;
      do begin
         bus(H_STATUS, 1'h0, '0);
         n++;
      end while (rdata[7:5] === old && n < 400);
   endtask

   function automatic logic [2:0] nx(input logic [2:0] i);
      return (i == 3'(NUM_CORES - 1)) ? 3'h0 : i + 3'h1;
   endfunction

   ////////////////////////////////////////////////////////////
   initial begin
      logic [2:0] idx;
      logic [13:0] prev;
      int t0;
      void'($urandom(83124));
      repeat (3) @(posedge clk);
      rst <= 1'h0;
      rd(H_STATUS, "status", 32'hFF, 32'h0);
      rd(H_DATA, "idle", 32'h8000_0000, 32'h0);
      bus(8'h20, 1'h1, $urandom);
      rd(8'h20, "unmapped", 32'hFFFF_FFFF, 32'h0);
      bus(H_CMD, 1'h1, 32'h1);
      wait_busy(1'h1);
      wait_busy(1'h0);
      repeat (20) @(posedge clk);
      rd(H_STATUS, "ready", 32'h17, 32'h11);
      // fifo is full by now, so the source has been refused meanwhile
      bus(H_DATA, 1'h0, '0);
      prev = rdata[13:0];
      repeat (8 + $urandom % 8) begin
         prev = prev + 14'h1;
         rd(H_DATA, "sample", 32'h8000_7FFF, {18'h20000, prev});
         repeat ($urandom % 3) @(posedge clk);
      end
      for (int k = 1; k <= 2; k++) begin
         bus(H_STATUS, 1'h0, '0);
         idx = rdata[7:5];
         bus(H_CMD, 1'h1, 32'h1 << k);
         wait_busy(1'h1);
         wait_busy(1'h0);
         repeat (2) @(posedge clk);
         rd(H_STATUS, "fg spare", 32'hE0, {24'h0, nx(idx), 5'h0});
         @(negedge clk);
         chk("cores", {27'h0, core_act}, 32'h1F & ~(32'h1 << nx(idx)));
      end
      bus(H_CTRL, 1'h1, 32'h1);
      repeat (4) @(posedge clk);
      rd(H_STATUS, "bg on", 32'h0C, 32'h0C);
      wait_idx(rdata[7:5]);
      t0 = cyc;
      idx = rdata[7:5];
      wait_idx(idx);
      chk("spare", {29'h0, rdata[7:5]}, {29'h0, nx(idx)});
      chk("period", 32'(cyc - t0 < SWAP + 8 && cyc - t0 > SWAP - 8), 1);
      bus(H_CTRL, 1'h1, 32'h5);
      bus(H_PINS, 1'h1, 32'h1);
      repeat (8) @(posedge clk);
      rd(H_STATUS, "frozen", 32'h0C, 32'h0);
      idx = rdata[7:5];
      repeat (SWAP + 50) @(posedge clk);
      rd(H_STATUS, "held", 32'hE0, {24'h0, idx, 5'h0});
      chk("spare pwr", {31'h0, spare_pwr}, 32'h0);
      bus(H_PINS, 1'h1, 32'h0);
      wait_idx(idx);
      chk("resumed", {29'h0, rdata[7:5]}, {29'h0, nx(idx)});
      bus(H_CTRL, 1'h1, 32'h3);
      repeat (4) @(posedge clk);
      rd(H_STATUS, "lp", 32'h04, 32'h04);
      // just after a swap the low power spare is still asleep
      wait_idx(rdata[7:5]);
      rd(H_STATUS, "lp wake", 32'h0C, 32'h04);
      chk("lp pwr", {31'h0, spare_pwr}, 32'h0);
      // stalled stream resumes: one count lost after the pending swaps
      for (int k = 1; k <= 10; k++) begin
         prev = prev + ((k == 10) ? 14'h2 : 14'h1);
         rd(H_DATA, "resume", 32'h8000_7FFF,
            {1'b1, 16'h0, (k == 10), prev});
      end
      @(posedge clk);
      test_done;
   end

   // watchdog, far beyond the expected run of under two thousand cycles
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      test_done;
   end
endmodule
